/* hw/pipelined_sync_sram_burst_port.sv */
// Pipelined synchronous memory with four-beat burst counter and queued write commit.
// Notes on behaviour
// - A load cycle (advance-or-load low) always ends any running burst.
// - Read-not-write is ignored on advance cycles of a burst.
// - Direction latched at load holds for every later beat of that burst.
// - Bursts step only the two low address bits, linear or interleaved.
// - Read-not-write low at a selected load starts a write, else a read.
// - Byte selects travel two cycles with the command to meet their data.
// - Clock enable high makes the edge absent; all state holds.
// - Selected only when both low selects are low and the high one high.
// - Burst order input high gives interleaved order; an undriven input is not read as high.
// - Read data drives the bus two enabled edges after its load.
// - The burst counter wraps after four beats and keeps counting.
`default_nettype none

module pipelined_sync_sram_burst_port
   import sram_port_pkg::*;
   (
      // Clock and reset
      input  wire logic              clk,
      input  wire logic              arst_n,
      // Command inputs
      input  wire logic [ADDR_W-1:0] address,
      input  wire logic              readNotWrite,
      input  wire logic              advanceOrLoad,
      input  wire logic [LANES-1:0]  byteWriteSelect_n,
      input  wire logic              clockEnable_n,
      input  wire logic              burstOrderSelect,
      // Chip selects
      input  wire logic              chipSelectLowA_n,
      input  wire logic              chipSelectLowB_n,
      input  wire logic              chipSelectHigh,
      // Data pins
      input  wire logic              outputEnable_n,
      input  wire logic [DATA_W-1:0] dataIn,
      output logic      [DATA_W-1:0] dataOut,
      output logic                   dataOe_n,
      // Write commit queue
      input  wire logic              commitHold,
      output logic                   writeQueueReady
   );

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      cmd_s               p1;
      cmd_s               p2;
      logic               burstActive;
      logic               burstDir;
      logic [ADDR_W-1:0]  baseAddr;
      logic [COUNT_W-1:0] count;
      logic               drive;
      logic [DATA_W-1:0]  dout;
   } state_s;

   localparam state_s STATE_RESET = '{p1: CMD_IDLE, p2: CMD_IDLE, burstActive: 1'b0, burstDir: 1'b0,
                                      baseAddr: '0, count: COUNT_START, drive: 1'b0, dout: '0};

   state_s              st_r;
   state_s              st_nxt;
   logic [DATA_W-1:0]   mem [MEM_DEPTH];
   logic [DATA_W-1:0]   memRead;
   logic                enabled;
   logic                selected;
   logic                pushValid;
   wr_entry_s           pushEntry;
   logic                popValid;
   logic                popReady;
   logic [WR_ENTRY_W-1:0] popBits;
   wr_entry_s           popEntry;
   logic [COUNT_W-1:0]  stepCount;

   assign enabled  = ~clockEnable_n;
   assign selected = ~chipSelectLowA_n & ~chipSelectLowB_n & chipSelectHigh;
   // Reads see memory before a commit on the same edge, so a write still in the queue is not forwarded.
   assign memRead  = mem[st_r.p2.addr];
   assign popEntry = wr_entry_s'(popBits);

   // ----------------------------------------------------------------
   // Command pipeline and burst counter
   // ----------------------------------------------------------------
   always_comb
   begin
      st_nxt    = st_r;
      pushValid = 1'b0;
      // Write data is taken from the pins at the edge its command leaves the second pipeline stage.
      pushEntry = '{addr: st_r.p2.addr, data: dataIn, bwN: st_r.p2.bwN};
      stepCount = COUNT_W'(st_r.count + COUNT_STEP);
      if (enabled)
      begin
         st_nxt.p2    = st_r.p1;
         st_nxt.drive = st_r.p2.valid & ~st_r.p2.isWrite;
         if (st_r.p2.valid && !st_r.p2.isWrite)
         begin
            st_nxt.dout = memRead;
         end
         if (st_r.p2.valid && st_r.p2.isWrite)
         begin
            pushValid = 1'b1;
         end
         if (!advanceOrLoad)
         begin
            if (selected)
            begin
               st_nxt.p1          = '{valid: 1'b1, isWrite: ~readNotWrite, addr: address,
                                      bwN: byteWriteSelect_n};
               st_nxt.burstActive = 1'b1;
               st_nxt.burstDir    = ~readNotWrite;
               st_nxt.baseAddr    = address;
               st_nxt.count       = COUNT_START;
            end
            else
            begin
               st_nxt.p1          = CMD_IDLE;
               st_nxt.burstActive = 1'b0;
            end
         end
         else if (st_r.burstActive)
         begin
            st_nxt.count = stepCount;
            st_nxt.p1    = '{valid: 1'b1, isWrite: st_r.burstDir,
                             addr: burstAddr(st_r.baseAddr, stepCount, burstOrderSelect),
                             bwN: byteWriteSelect_n};
         end
         else
         begin
            st_nxt.p1 = CMD_IDLE;
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         st_r <= STATE_RESET;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Data pins
   // ----------------------------------------------------------------
   assign dataOut  = st_r.dout;
   assign dataOe_n = ~(st_r.drive & ~outputEnable_n);

   // ----------------------------------------------------------------
   // Write commit queue and storage
   // ----------------------------------------------------------------
   // A write that meets a full queue is dropped; writeQueueReady low warns the controller.
   // The queue commits while the clock is enabled and no hold is requested.
   assign popReady = enabled & ~commitHold;

   write_queue
      #(
         .WIDTH (WR_ENTRY_W),
         .DEPTH (FIFO_DEPTH)
      )
   u_write_queue
      (
         .clk      (clk),
         .arst_n   (arst_n),
         .inValid  (pushValid),
         .inReady  (writeQueueReady),
         .inData   (pushEntry),
         .outValid (popValid),
         .outReady (popReady),
         .outData  (popBits)
      );

   always_ff @(posedge clk)
   begin
      if (popValid && popReady)
      begin
         for (int i = 0; i < LANES; i++)
         begin
            if (!popEntry.bwN[i])
            begin
               mem[popEntry.addr][i*LANE_W +: LANE_W] <= popEntry.data[i*LANE_W +: LANE_W];
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);

   sequence s_loadRead;
      enabled && !advanceOrLoad && selected && readNotWrite;
   endsequence

   sequence s_loadWrite;
      enabled && !advanceOrLoad && selected && !readNotWrite;
   endsequence

   sequence s_advance;
      enabled && advanceOrLoad && st_r.burstActive;
   endsequence

   sequence s_deselect;
      enabled && !advanceOrLoad && !selected;
   endsequence

   // Each sequence above names one kind of enabled command edge; the properties chain them.
   sequence s_noop;
      enabled && advanceOrLoad && !st_r.burstActive;
   endsequence

   sequence s_twoEnabled;
      enabled ##1 enabled;
   endsequence

   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------

   chk_read_latency: assert property (s_loadRead ##1 enabled ##1 enabled |=> st_r.drive)
      else $error("read data not driven two enabled edges after load");

   chk_write_select: assert property (s_loadWrite ##1 enabled ##1 enabled
                                      |-> pushValid && pushEntry.bwN == $past(byteWriteSelect_n, 2))
      else $error("write data not paired with its byte selects");

   chk_deselect_idle: assert property (s_deselect |=> !st_r.p1.valid && !st_r.burstActive)
      else $error("deselect started an access or kept a burst");

   chk_suspend_hold: assert property (clockEnable_n |=> $stable(st_r))
      else $error("state changed on a suspended edge");

   chk_dir_kept: assert property (s_advance |=> st_r.p1.valid && st_r.p1.isWrite == $past(st_r.burstDir))
      else $error("burst beat changed direction");

   chk_high_bits: assert property (s_advance |=> st_r.p1.addr[ADDR_W-1:COUNT_W]
                                   == $past(st_r.baseAddr[ADDR_W-1:COUNT_W]))
      else $error("burst moved address bits above the low two");

   chk_count_wrap: assert property (s_advance |=> st_r.count == $past(st_r.count) + COUNT_STEP)
      else $error("burst counter did not step with wrap");

   chk_load_stop: assert property (s_loadRead |=> st_r.count == COUNT_START && !st_r.burstDir)
      else $error("load did not restart the burst");

   chk_bus_idle: assert property (!st_r.drive || outputEnable_n |-> dataOe_n)
      else $error("data pins driven outside a read data cycle");

   chk_oe_gate: assert property (outputEnable_n |-> dataOe_n)
      else $error("data pins driven while output enable is high");

   chk_load_read: assert property (s_loadRead |=> st_r.p1.valid && !st_r.p1.isWrite
                                   && st_r.p1.addr == $past(address))
      else $error("read load did not start a read at its address");

   chk_load_write: assert property (s_loadWrite |=> st_r.p1.valid && st_r.p1.isWrite && st_r.burstDir
                                    && st_r.p1.bwN == $past(byteWriteSelect_n))
      else $error("write load did not start a write with its byte selects");

   chk_write_quiet: assert property (s_loadWrite ##1 s_twoEnabled |=> !st_r.drive)
      else $error("data pins prepared for a write data cycle");

   chk_write_addr: assert property (s_loadWrite ##1 s_twoEnabled |-> pushEntry.addr == $past(address, 2))
      else $error("write data paired with the wrong address");

   chk_noop_idle: assert property (s_noop |=> !st_r.p1.valid && !st_r.burstActive)
      else $error("advance without a burst started an access");

   chk_read_drain: assert property (s_loadRead ##1 s_deselect ##1 s_deselect |=> st_r.drive)
      else $error("deselect cut off a pending read");

   chk_write_drain: assert property (s_loadWrite ##1 s_deselect ##1 s_deselect |-> pushValid)
      else $error("deselect cut off a pending write");

   chk_linear_step: assert property (s_advance ##0 !burstOrderSelect |=> st_r.p1.addr[COUNT_W-1:0]
                                     == COUNT_W'(st_r.baseAddr[COUNT_W-1:0] + st_r.count))
      else $error("linear burst stepped to the wrong low address bits");

   chk_order_high: assert property (s_advance ##0 burstOrderSelect |=> st_r.p1.addr[COUNT_W-1:0]
                                    == (st_r.baseAddr[COUNT_W-1:0] ^ st_r.count))
      else $error("high burst order select did not interleave");

   chk_beat_selects: assert property (s_advance |=> st_r.p1.bwN == $past(byteWriteSelect_n))
      else $error("burst beat lost its byte selects");

   chk_count_reload: assert property (s_advance ##0 st_r.count == COUNT_W'(COUNT_START - COUNT_STEP)
                                      |=> st_r.count == COUNT_START)
      else $error("burst counter did not return to its start");

   chk_suspend_quiet: assert property (clockEnable_n |-> !pushValid && !(popValid && popReady))
      else $error("write queue moved on a suspended edge");

   chk_dout_hold: assert property (clockEnable_n |=> $stable(dataOut))
      else $error("read data changed on a suspended edge");

endmodule : pipelined_sync_sram_burst_port

`default_nettype wire

/* hw/sram_port_pkg.sv */
// Shared constants, types and address stepping for the pipelined burst memory port.
`default_nettype none

package sram_port_pkg;

   // ----------------------------------------------------------------
   // Geometry
   // ----------------------------------------------------------------
   localparam int ADDR_W     = 17;
   localparam int DATA_W     = 36;
   localparam int LANES      = 4;
   localparam int LANE_W     = 9;
   localparam int MEM_DEPTH  = 131072;
   localparam int COUNT_W    = 2;
   localparam int FIFO_DEPTH = 8;

   // ----------------------------------------------------------------
   // Field values and reset values
   // ----------------------------------------------------------------
   localparam logic [COUNT_W-1:0] COUNT_START = 2'h0;
   localparam logic [COUNT_W-1:0] COUNT_STEP  = 2'h1;
   localparam logic [LANES-1:0]   LANES_OFF_N = 4'hf;
   localparam logic               ORDER_INTERLEAVED = 1'b1;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic              valid;
      logic              isWrite;
      logic [ADDR_W-1:0] addr;
      logic [LANES-1:0]  bwN;
   } cmd_s;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
      logic [LANES-1:0]  bwN;
   } wr_entry_s;

   localparam int WR_ENTRY_W = $bits(wr_entry_s);

   localparam cmd_s CMD_IDLE = '{valid: 1'b0, isWrite: 1'b0, addr: '0, bwN: LANES_OFF_N};

   // ----------------------------------------------------------------
   // Burst address stepping
   // ----------------------------------------------------------------
   // Only the two lowest bits move; high order selects interleaved, low selects linear.
   function automatic logic [ADDR_W-1:0] burstAddr(input logic [ADDR_W-1:0]  base,
                                                   input logic [COUNT_W-1:0] count,
                                                   input logic               order);
      logic [COUNT_W-1:0] low;
      low = (order == ORDER_INTERLEAVED) ? (base[COUNT_W-1:0] ^ count)
                                         : COUNT_W'(base[COUNT_W-1:0] + count);
      return {base[ADDR_W-1:COUNT_W], low};
   endfunction : burstAddr

endpackage : sram_port_pkg

`default_nettype wire

/* hw/write_queue.sv */
// Parameterised first-in first-out queue with valid and ready on both sides.
`default_nettype none

module write_queue
   #(
      parameter int WIDTH = 8,
      parameter int DEPTH = 8
   )
   (
      // Clock and reset
      input  wire logic             clk,
      input  wire logic             arst_n,
      // Filling side
      input  wire logic             inValid,
      output logic                  inReady,
      input  wire logic [WIDTH-1:0] inData,
      // Draining side
      output logic                  outValid,
      input  wire logic             outReady,
      output logic [WIDTH-1:0]      outData
   );

   localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CNT_W = $clog2(DEPTH + 1);
   localparam logic [PTR_W-1:0] LAST = PTR_W'(DEPTH - 1);
   localparam logic [CNT_W-1:0] FULL = CNT_W'(DEPTH);

   typedef struct packed {
      logic [PTR_W-1:0] rdPtr;
      logic [PTR_W-1:0] wrPtr;
      logic [CNT_W-1:0] count;
   } fifo_state_s;

   fifo_state_s          st_r;
   fifo_state_s          st_nxt;
   logic [WIDTH-1:0]     store [DEPTH];
   logic                 pushFire;
   logic                 popFire;

   // ----------------------------------------------------------------
   // Flags
   // ----------------------------------------------------------------
   assign inReady  = (st_r.count != FULL);
   assign outValid = (st_r.count != '0);
   assign outData  = store[st_r.rdPtr];
   assign pushFire = inValid & inReady;
   assign popFire  = outValid & outReady;

   // ----------------------------------------------------------------
   // Pointers and fill level
   // ----------------------------------------------------------------
   always_comb
   begin
      st_nxt = st_r;
      if (pushFire)
      begin
         st_nxt.wrPtr = (st_r.wrPtr == LAST) ? '0 : PTR_W'(st_r.wrPtr + 1'b1);
      end
      if (popFire)
      begin
         st_nxt.rdPtr = (st_r.rdPtr == LAST) ? '0 : PTR_W'(st_r.rdPtr + 1'b1);
      end
      if (pushFire && !popFire)
      begin
         st_nxt.count = CNT_W'(st_r.count + 1'b1);
      end
      else if (popFire && !pushFire)
      begin
         st_nxt.count = CNT_W'(st_r.count - 1'b1);
      end
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         st_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   always_ff @(posedge clk)
   begin
      if (pushFire)
      begin
         store[st_r.wrPtr] <= inData;
      end
   end

endmodule : write_queue

`default_nettype wire

/* tb/mem_ctrl_model.sv */
// Controller-side model that presents write data two enabled edges after its command.
`default_nettype none

module mem_ctrl_model
   import sram_port_pkg::*;
   (
      // Clock and reset
      input  wire logic              clk,
      input  wire logic              arst_n,
      // Observed command pins
      input  wire logic              clockEnable_n,
      input  wire logic              advanceOrLoad,
      input  wire logic              readNotWrite,
      input  wire logic              selected,
      // Data supplied with each command and the data pins
      input  wire logic [DATA_W-1:0] wrWord,
      output logic      [DATA_W-1:0] dataIn
   );
   timeunit 1ns;
   timeprecision 1ns;

   logic              burstWr_r;
   logic [1:0]        pend_r;
   logic [DATA_W-1:0] word_r [2];
   logic              isWr;

   assign isWr = advanceOrLoad ? burstWr_r : (selected & ~readNotWrite);

   always @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         burstWr_r <= 1'b0;
         pend_r <= 2'h0;
      end
      else if (!clockEnable_n)
      begin
         if (!advanceOrLoad)
            burstWr_r <= selected & ~readNotWrite;
         pend_r <= {pend_r[0], isWr};
         word_r[1] <= word_r[0];
         word_r[0] <= wrWord;
      end
   end

   initial dataIn = '0;

   // Lines outside a write data cycle change every cycle, so a stale word is never mistaken for data.
   always @(negedge clk)
      dataIn <= pend_r[1] ? word_r[1] : ~dataIn;
endmodule : mem_ctrl_model

`default_nettype wire

/* tb/pipelined_sync_sram_burst_port_tb_top.sv */
// Self-checking bench for the pipelined burst memory port.
`default_nettype none

module pipelined_sync_sram_burst_port_tb_top
   import sram_port_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ns;

   typedef struct packed {
      logic [ADDR_W-1:0] a;
      logic [LANES-1:0]  bw;
      logic [DATA_W-1:0] w;
   } row_s;

   localparam logic [2:0] SEL = 3'b001;

   logic              clk, arst_n, readNotWrite, advanceOrLoad, clockEnable_n, burstOrderSelect;
   logic              chipSelectLowA_n, chipSelectLowB_n, chipSelectHigh, outputEnable_n, commitHold;
   logic              dataOe_n, writeQueueReady, selected, run, dirW, expKnown;
   logic              expRd = 1'b0;
   logic [ADDR_W-1:0] address, base;
   logic [LANES-1:0]  byteWriteSelect_n;
   logic [DATA_W-1:0] dataIn, dataOut, wrWord, expVal;
   logic [1:0]        cnt;
   logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
   cmd_s              p0, p1;
   int                failures, testsRun, qCnt;
   row_s              rows [9] = '{'{17'h00040, 4'h0, 36'h1_2345_6789}, '{17'h00041, 4'h0, 36'h2_468a_cf13},
      '{17'h00042, 4'h0, 36'h3_0f0f_0f0f}, '{17'h00043, 4'h0, 36'h4_f0f0_f0f0}, '{17'h1ffff, 4'h0, 36'hf_ffff_ffff},
      '{17'h00000, 4'h0, 36'h0_0000_0000}, '{17'h00041, 4'ha, 36'h5_5555_5555}, '{17'h00108, 4'h0, 36'h6_0000_0108},
      '{17'h00109, 4'h0, 36'h7_0000_0109}};

   pipelined_sync_sram_burst_port pipelined_sync_sram_burst_port_i (.clk, .arst_n, .address, .readNotWrite,
      .advanceOrLoad, .byteWriteSelect_n, .clockEnable_n, .burstOrderSelect, .chipSelectLowA_n, .chipSelectLowB_n,
      .chipSelectHigh, .outputEnable_n, .dataIn, .dataOut, .dataOe_n, .commitHold, .writeQueueReady);

   mem_ctrl_model mem_ctrl_model_i (.clk, .arst_n, .clockEnable_n, .advanceOrLoad, .readNotWrite, .selected,
      .wrWord, .dataIn);

   assign selected = ~chipSelectLowA_n & ~chipSelectLowB_n & chipSelectHigh;

   always #50 clk = ~clk;

   // Reference pipeline: what each enabled edge should complete two enabled edges later.
   always @(posedge clk or negedge arst_n)
   begin : refModel
      cmd_s              c;
      logic [DATA_W-1:0] t;
      logic              push, drain;
      if (!arst_n)
      begin
         run = 1'b0;
         p0 = CMD_IDLE;
         p1 = CMD_IDLE;
         expRd = 1'b0;
         qCnt = 0;
      end
      else if (!clockEnable_n)
      begin
         c = CMD_IDLE;
         if (!advanceOrLoad)
         begin
            run = selected;
            dirW = ~readNotWrite;
            base = address;
            cnt = COUNT_START;
         end
         else if (run)
            cnt = cnt + COUNT_STEP;
         if (run)
            c = '{1'b1, dirW, {base[ADDR_W-1:2], (burstOrderSelect !== ~ORDER_INTERLEAVED) ? base[1:0] ^ cnt :
                  base[1:0] + cnt}, byteWriteSelect_n};
         expRd = p1.valid & ~p1.isWrite;
         expKnown = (mem.exists(p1.addr) != 0);
         if (expRd && expKnown)
            expVal = mem[p1.addr];
         push = p1.valid & p1.isWrite & (qCnt < FIFO_DEPTH);
         drain = (qCnt > 0) & ~commitHold;
         if (push)
         begin
            t = expKnown ? mem[p1.addr] : '0;
            for (int i = 0; i < LANES; i++)
               if (!p1.bwN[i])
                  t[i*LANE_W +: LANE_W] = dataIn[i*LANE_W +: LANE_W];
            mem[p1.addr] = t;
         end
         qCnt = qCnt + int'(push) - int'(drain);
         p1 = p0;
         p0 = c;
      end
   end

   task automatic chkBit(input string name, input logic seen, input logic exp);
      testsRun++;
      if (seen !== exp)
      begin
         failures++;
         $display("[FAIL] %s expected %b seen %b", name, exp, seen);
      end
   endtask : chkBit

   task automatic chkWord(input string name, input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
      testsRun++;
      if (seen !== exp)
      begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask : chkWord

   always @(negedge clk)
   begin
      #25;
      chkBit("dataOe_n", dataOe_n, ~(expRd & ~outputEnable_n));
      chkBit("writeQueueReady", writeQueueReady, qCnt < FIFO_DEPTH);
      if (expRd && expKnown)
         chkWord("dataOut", dataOut, expVal);
   end

   task automatic drive(input logic [ADDR_W-1:0] a, input logic rnw, adv, input logic [2:0] cs, input logic clock_enable_n,
                        input logic [LANES-1:0] bw, input logic [DATA_W-1:0] w);
      @(negedge clk);
      address = a;
      readNotWrite = rnw;
      advanceOrLoad = adv;
      {chipSelectLowA_n, chipSelectLowB_n, chipSelectHigh} = cs;
      clockEnable_n = clock_enable_n;
      byteWriteSelect_n = bw;
      wrWord = w;
   endtask : drive

   task automatic ld(input logic [ADDR_W-1:0] a, input logic rnw, input logic [LANES-1:0] bw,
                     input logic [DATA_W-1:0] w);
      drive(a, rnw, 1'b0, SEL, 1'b0, bw, w);
   endtask : ld

   // Advance beats carry a junk address and deselect pattern, which must both be ignored.
   task automatic adv(input logic rnw, input logic [DATA_W-1:0] w);
      drive('1, rnw, 1'b1, 3'b110, 1'b0, 4'h0, w);
   endtask : adv

   task automatic idle(input int n);
      repeat (n) drive('0, 1'b0, 1'b0, 3'b110, 1'b0, 4'h0, '0);
   endtask : idle

   task automatic conclude;
      $display("Checks run: %0d, failures: %0d", testsRun, failures);
      if (failures == 0 && testsRun > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : conclude

   initial
   begin
      repeat (3000) @(posedge clk);
      failures++;
      conclude();
   end

   initial
   begin
      clk = 1'b0;
      arst_n = 1'b0;
      {address, readNotWrite, advanceOrLoad, byteWriteSelect_n, clockEnable_n, wrWord} = '0;
      {chipSelectLowA_n, chipSelectLowB_n, chipSelectHigh} = 3'b110;
      {outputEnable_n, commitHold, burstOrderSelect} = 3'b001;
      repeat (2) @(posedge clk);
      @(negedge clk);
      arst_n = 1'b1;
      foreach (rows[i]) ld(rows[i].a, 1'b0, rows[i].bw, rows[i].w);
      idle(4);
      foreach (rows[i]) ld(rows[i].a, 1'b1, 4'hf, '0);
      idle(3);
      for (int o = 0; o < 2; o++)
      begin
         burstOrderSelect = o[0];
         ld(17'h00041, 1'b1, 4'hf, '0);
         for (int k = 0; k < 6; k++) adv(k[0], '0);
         outputEnable_n = 1'b1;
         ld(17'h00040, 1'b1, 4'hf, '0);
         outputEnable_n = 1'b0;
         idle(3);
      end
      ld(17'h00042, 1'b0, 4'h0, 36'ha_0000_0001);
      adv(1'b1, 36'ha_0000_0002);
      drive(17'h00123, 1'b0, 1'b0, SEL, 1'b1, 4'h0, '1);
      adv(1'b1, 36'ha_0000_0003);
      adv(1'b1, 36'ha_0000_0004);
      idle(5);
      ld(17'h00040, 1'b1, 4'hf, '0);
      repeat (2) drive(17'h00041, 1'b0, 1'b0, SEL, 1'b1, 4'h0, '1);
      repeat (3) adv(1'b0, '0);
      idle(3);
      for (int k = 0; k < 3; k++) drive(17'h00043, 1'b0, 1'b0, 3'b001 ^ (3'b100 >> k), 1'b0, 4'h0, '1);
      adv(1'b0, '1);
      ld(17'h00043, 1'b1, 4'hf, '0);
      idle(3);
      commitHold = 1'b1;
      for (int k = 0; k < 10; k++) ld(ADDR_W'(32'h108 - k), 1'b0, 4'h0, DATA_W'(k));
      idle(4);
      commitHold = 1'b0;
      idle(12);
      for (int k = 0; k < 10; k++) ld(ADDR_W'(32'h108 - k), 1'b1, 4'hf, '0);
      ld(17'h00040, 1'b1, 4'hf, '0);
      adv(1'b1, '0);
      arst_n = 1'b0;
      idle(2);
      arst_n = 1'b1;
      adv(1'b1, '0);
      idle(3);
      conclude();
   end
endmodule : pipelined_sync_sram_burst_port_tb_top

`default_nettype wire
